// file: logic/pfbc_pkg.sv
// Shared constants, types and helpers of the pulse flow batch counter
`default_nettype none
package pfbc_pkg;
  // Clock and time base
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;
  localparam int ZERO_LEVEL_US = 5000;
  localparam logic [15:0] AR_SEC_TICKS = 16'h0001;
  localparam logic [15:0] AR_MIN_TICKS = 16'h003c;
  // Register addresses
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_ZERO_T = 8'h01;
  localparam logic [7:0] A_MIN_MEASURE_WINDOW = 8'h02;
  localparam logic [7:0] A_PPU_LO = 8'h03;
  localparam logic [7:0] A_PPU_HI = 8'h04;
  localparam logic [7:0] A_RATE_LO = 8'h05;
  localparam logic [7:0] A_RATE_HI = 8'h06;
  localparam logic [7:0] A_BSF_LO = 8'h07;
  localparam logic [7:0] A_BSF_HI = 8'h08;
  localparam logic [7:0] A_AR_DLY = 8'h09;
  localparam logic [7:0] A_BAT_HI = 8'h0d;
  localparam logic [7:0] A_BAT_LO = 8'h0e;
  localparam logic [7:0] A_BAT_ST = 8'h0f;
  localparam logic [7:0] A_FLOW_HI = 8'h10;
  localparam logic [7:0] A_FLOW_LO = 8'h11;
  localparam logic [7:0] A_STAT = 8'h12;
  // Field positions of the configuration word, and of the decimal point in the factor high words
  localparam int F_MAX_INPUT_FREQUENCY = 0;
  localparam int F_PERIOD = 4;
  localparam int F_KILO = 5;
  localparam int F_TUNIT = 6;
  localparam int F_ZMODE = 8;
  localparam int F_MAN = 11;
  localparam int F_AR_EN = 12;
  localparam int F_AR_MIN = 13;
  localparam int F_DP = 4;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Limits and scales
  localparam logic [15:0] ZERO_T_MAX = 16'h018f;
  localparam logic [15:0] MIN_MEASURE_WINDOW_MAX = 16'h00c7;
  localparam logic [19:0] FACTOR_MAX = 20'hf423f;
  localparam logic [19:0] PPU_ZERO_AS = 20'hf4240;
  localparam logic [2:0] DP_MAX = 3'h6;
  localparam logic [31:0] BATCH_LIMIT = 32'h03e7ffff;
  localparam int MILLI = 1000;
  localparam int PULSE_MILLI = 100000;
  localparam int TENTHS = 10;
  localparam int PPU_SCALE = 100;
  localparam int KILO = 1000;
  localparam int DIVW = 80;
  // Zeroing input modes and divider jobs
  typedef enum logic [2:0] {zm_off, zm_high, zm_low, rising_edge_select,
    falling_edge_select} pfbc_zmode_t;
  typedef enum logic [1:0] {job_idle, job_delta, job_conv, job_flow}
    pfbc_job_t;
  // Least stable time of an input state per max_input_frequency, in us
  function automatic int filt_us(input logic [3:0] idx);
    case (idx)
      4'h0: filt_us = 5000;
      4'h1: filt_us = 3400;
      4'h2: filt_us = 2500;
      4'h3: filt_us = 1700;
      4'h4: filt_us = 1300;
      4'h5: filt_us = 1000;
      4'h6: filt_us = 500;
      4'h7: filt_us = 167;
      4'h8: filt_us = 50;
      default: filt_us = 33;
    endcase
  endfunction
  // Ten to the power of a decimal point position
  function automatic logic [19:0] pow10(input logic [2:0] dp);
    logic [19:0] p;
    p = 20'h00001;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(dp)) p = 20'(p * 20'h0000a);
    end
    pow10 = p;
  endfunction
endpackage : pfbc_pkg
`default_nettype wire

// file: logic/pfbc_cond_if.sv
// Cleaned input level and edges passed from a filter to the core
`timescale 1ns/1ps
`default_nettype none
interface pfbc_cond_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : pfbc_cond_if
`default_nettype wire

// file: logic/pfbc_input_filter.sv
// Pin synchroniser and glitch filter with a programmable stable time
`timescale 1ns/1ps
`default_nettype none
module pfbc_input_filter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw pin and least stable time in cycles
  input wire logic pin,
  input wire logic [23:0] min_cnt,
  // Cleaned level and one-cycle edges
  pfbc_cond_if.src cond
);
  logic s1_q, s2_q;
  logic [23:0] cnt_q;

  // Two flops before anything looks at the pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  // A new state counts only once it has stood for min_cnt cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= 24'h0;
      cond.level <= 1'b0;
      cond.rise <= 1'b0;
      cond.fall <= 1'b0;
    end else begin
      cond.rise <= 1'b0;
      cond.fall <= 1'b0;
      if (s2_q == cond.level) begin
        cnt_q <= 24'h0;
      end else if (24'(cnt_q + 24'h1) >= min_cnt) begin
        cnt_q <= 24'h0;
        cond.level <= s2_q;
        cond.rise <= s2_q;
        cond.fall <= ~s2_q;
      end else begin
        cnt_q <= 24'(cnt_q + 24'h1);
      end
    end
  end
endmodule // pfbc_input_filter
`default_nettype wire

// file: logic/pfbc_tick.sv
// Tenth-of-a-second time base
`timescale 1ns/1ps
`default_nettype none
module pfbc_tick #(
  parameter int TICK_CYCLES = 25000000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // One-cycle pulse every tick period
  output logic tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  logic [CW-1:0] cnt_q;

  // Free-running divider
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : CW'(cnt_q + 1'b1);
    end
  end
endmodule // pfbc_tick
`default_nettype wire

// file: logic/pfbc_top.sv
// Pulse flow rate measurement and batch counter core
`timescale 1ns/1ps
`default_nettype none
module pfbc_top import pfbc_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int FILT_US_CYCLES = CLK_MHZ
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Pins from sensor and panel
  input wire logic flow_pulse,
  input wire logic zero_in,
  input wire logic sum_button,
  input wire logic clear_menu,
  input wire logic confirm_key,
  input wire logic cancel_key,
  input wire logic batch_done,
  // Results
  output logic [31:0] flow_rate,
  output logic [31:0] batch_value,
  output logic batch_overload,
  output logic no_flow,
  output logic clear_prompt
);
  logic [15:0] cfg_q, zero_t_q, meas_q, ar_dly_q;
  logic [19:0] ppu_q, rate_q, bsf_q;
  logic [2:0] rdp_q, bdp_q;
  logic [4:0] k1_q, k2_q, k3_q, krise;
  logic tick, no_flow_q, start_q, jto_q, prompt_q, run_q;
  logic [15:0] win_q, gap_q, pcount_q, jp_q, jt_q, meas_eff, lim_ticks;
  logic timeout, wclose, clr, clr_lvl, clr_edge, clr_ser, clr_ar, done;
  logic raw_stop_q, lock_q, ovl_q, ar_run_q;
  logic [31:0] raw_q, conv_q, flow_q, res32;
  logic [15:0] ar_cnt_q, ar_pre_q, ar_step;
  logic [19:0] ppu_eff;
  logic [DIVW-1:0] rem_q, quo_q, den_q, op_num, op_den, n0, d0;
  logic [DIVW:0] trial;
  logic [6:0] cnt_q;
  logic [32:0] raw_sum;
  pfbc_job_t job_q;
  pfbc_zmode_t zmode;
  pfbc_cond_if pc ();
  pfbc_cond_if zc ();

  ////////////////////////////////////////////////////////////////////////
  // disturbance rejection
  pfbc_input_filter u_pulse_filt (.mclk(mclk), .rst(rst), .pin(flow_pulse),
    .min_cnt(24'(filt_us(cfg_q[F_MAX_INPUT_FREQUENCY +: 4]) * FILT_US_CYCLES)),
    .cond(pc.src));
  // Zeroing input is held to the level-mode minimum, so spikes never clear
  pfbc_input_filter u_zero_filt (.mclk(mclk), .rst(rst), .pin(zero_in),
    .min_cnt(24'(ZERO_LEVEL_US * FILT_US_CYCLES)), .cond(zc.src));
  pfbc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (.mclk(mclk), .rst(rst),
    .tick(tick));

  // Panel keys and batch end cross in through two flops, third finds edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      k1_q <= 5'h00;
      k2_q <= 5'h00;
      k3_q <= 5'h00;
    end else begin
      k1_q <= {batch_done, cancel_key, confirm_key, clear_menu, sum_button};
      k2_q <= k1_q;
      k3_q <= k2_q;
    end
  end
  assign krise = k2_q & ~k3_q;

  ////////////////////////////////////////////////////////////////////////
  // Register writes; zero time, window and decimal points are clamped
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q <= CFG_RST;
      zero_t_q <= 16'h0000;
      meas_q <= 16'h0000;
      ppu_q <= 20'h00000;
      rate_q <= 20'h00001;
      bsf_q <= 20'h00001;
      rdp_q <= 3'h0;
      bdp_q <= 3'h0;
      ar_dly_q <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        A_CFG: cfg_q <= reg_wdata;
        A_ZERO_T: zero_t_q <= (reg_wdata > ZERO_T_MAX) ? ZERO_T_MAX : reg_wdata;
        A_MIN_MEASURE_WINDOW: meas_q <= (reg_wdata > MIN_MEASURE_WINDOW_MAX) ? MIN_MEASURE_WINDOW_MAX : reg_wdata;
        A_PPU_LO: ppu_q[15:0] <= reg_wdata;
        A_PPU_HI: ppu_q[19:16] <= reg_wdata[3:0];
        A_RATE_LO: rate_q[15:0] <= reg_wdata;
        A_RATE_HI: begin
          rate_q[19:16] <= reg_wdata[3:0];
          rdp_q <= (reg_wdata[F_DP +: 3] > DP_MAX) ? DP_MAX : reg_wdata[F_DP +: 3];
        end
        A_BSF_LO: bsf_q[15:0] <= reg_wdata;
        A_BSF_HI: begin
          bsf_q[19:16] <= reg_wdata[3:0];
          bdp_q <= (reg_wdata[F_DP +: 3] > DP_MAX) ? DP_MAX : reg_wdata[F_DP +: 3];
        end
        A_AR_DLY: ar_dly_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, answered in the following cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        A_CFG: reg_rdata <= cfg_q;
        A_ZERO_T: reg_rdata <= zero_t_q;
        A_MIN_MEASURE_WINDOW: reg_rdata <= meas_q;
        A_PPU_LO: reg_rdata <= ppu_q[15:0];
        A_PPU_HI: reg_rdata <= {12'h000, ppu_q[19:16]};
        A_RATE_LO: reg_rdata <= rate_q[15:0];
        A_RATE_HI: reg_rdata <= {9'h000, rdp_q, rate_q[19:16]};
        A_BSF_LO: reg_rdata <= bsf_q[15:0];
        A_BSF_HI: reg_rdata <= {9'h000, bdp_q, bsf_q[19:16]};
        A_AR_DLY: reg_rdata <= ar_dly_q;
        A_BAT_HI: reg_rdata <= conv_q[31:16];
        A_BAT_LO: reg_rdata <= conv_q[15:0];
        A_BAT_ST: reg_rdata <= {13'h0000, lock_q, raw_stop_q, ovl_q};
        A_FLOW_HI: reg_rdata <= flow_q[31:16];
        A_FLOW_LO: reg_rdata <= flow_q[15:0];
        A_STAT: reg_rdata <= {12'h000, ar_run_q, prompt_q, run_q, no_flow_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timeout floor is the window
  assign meas_eff = (meas_q == 16'h0) ? 16'h0001 : meas_q;
  assign lim_ticks = (zero_t_q < meas_eff) ? meas_eff : zero_t_q;
  assign timeout = !no_flow_q && (gap_q > lim_ticks);
  // window closes only on a pulse
  assign wclose = !no_flow_q && pc.rise && (win_q >= meas_eff);

  always_ff @(posedge mclk) begin
    if (rst) begin
      no_flow_q <= 1'b1;
      win_q <= 16'h0;
      gap_q <= 16'h0;
      pcount_q <= 16'h0;
      start_q <= 1'b0;
      jp_q <= 16'h0;
      jt_q <= 16'h0;
      jto_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (pc.rise) gap_q <= 16'h0;
      else if (tick && gap_q != 16'hffff) gap_q <= 16'(gap_q + 16'h1);
      if (pc.rise && no_flow_q) begin
        // First pulse after idle only opens a window
        no_flow_q <= 1'b0;
        win_q <= 16'h0;
        pcount_q <= 16'h0;
      end else if (wclose) begin
        start_q <= 1'b1;
        jp_q <= 16'(pcount_q + 16'h1);
        jt_q <= win_q;
        jto_q <= 1'b0;
        win_q <= 16'h0;
        pcount_q <= 16'h0;
      end else if (timeout) begin
        // Pulses already seen still reach the batch
        no_flow_q <= 1'b1;
        start_q <= (pcount_q != 16'h0);
        jp_q <= pcount_q;
        jt_q <= win_q;
        jto_q <= 1'b1;
        pcount_q <= 16'h0;
      end else begin
        if (pc.rise) pcount_q <= 16'(pcount_q + 16'h1);
        if (tick && win_q != 16'hffff) win_q <= 16'(win_q + 16'h1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // zero means one million
  assign ppu_eff = (ppu_q == 20'h0) ? PPU_ZERO_AS : ppu_q;
  assign n0 = DIVW'(jp_q) * DIVW'(rate_q) * DIVW'(TENTHS * PPU_SCALE)
    * DIVW'((cfg_q[F_TUNIT +: 2] == 2'h0) ? 1 :
            (cfg_q[F_TUNIT +: 2] == 2'h1) ? 60 : 3600);
  assign d0 = DIVW'(ppu_eff) * DIVW'(pow10(rdp_q)) * DIVW'(jt_q)
    * DIVW'(cfg_q[F_KILO] ? KILO : 1);

  // Operands of each divider job
  always_comb begin
    op_num = '0;
    op_den = '0;
    case (job_q)
      job_delta: begin
        op_num = DIVW'(jp_q) * DIVW'(PULSE_MILLI);
        op_den = DIVW'(ppu_eff);
      end
      job_conv: begin
        op_num = DIVW'(raw_q) * DIVW'(bsf_q);
        op_den = DIVW'(pow10(bdp_q));
      end
      job_flow: begin
        op_num = cfg_q[F_PERIOD] ? DIVW'(d0 * DIVW'(MILLI)) : DIVW'(n0 * DIVW'(MILLI));
        op_den = cfg_q[F_PERIOD] ? n0 : d0;
      end
      default: ;
    endcase
  end

  // Shared restoring divider; a zero divisor saturates the result
  assign trial = {rem_q, quo_q[DIVW-1]};
  assign done = run_q && (cnt_q == 7'h0);
  assign res32 = (|quo_q[DIVW-1:32]) ? 32'hffffffff : quo_q[31:0];
  always_ff @(posedge mclk) begin
    if (rst) begin
      job_q <= job_idle;
      run_q <= 1'b0;
      cnt_q <= 7'h0;
      rem_q <= '0;
      quo_q <= '0;
      den_q <= '0;
    end else if (run_q) begin
      if (done) begin
        run_q <= 1'b0;
        case (job_q)
          job_delta: job_q <= job_conv;
          job_conv: job_q <= job_flow;
          default: job_q <= job_idle;
        endcase
      end else begin
        cnt_q <= 7'(cnt_q - 7'h1);
        if (trial >= {1'b0, den_q}) begin
          rem_q <= DIVW'(trial - {1'b0, den_q});
          quo_q <= {quo_q[DIVW-2:0], 1'b1};
        end else begin
          rem_q <= trial[DIVW-1:0];
          quo_q <= {quo_q[DIVW-2:0], 1'b0};
        end
      end
    end else if (job_q != job_idle) begin
      run_q <= 1'b1;
      cnt_q <= 7'(DIVW);
      rem_q <= '0;
      quo_q <= op_num;
      den_q <= op_den;
    end else if (start_q) begin
      job_q <= job_delta;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) flow_q <= 32'h0;
    else if (timeout) flow_q <= 32'h0;
    else if (done && job_q == job_flow) flow_q <= jto_q ? 32'h0 : res32;
  end

  ////////////////////////////////////////////////////////////////////////
  // Clear sources
  assign zmode = pfbc_zmode_t'(cfg_q[F_ZMODE +: 3]);
  assign clr_lvl = (zmode == zm_high && zc.level)
    || (zmode == zm_low && !zc.level);
  assign clr_edge = (zmode == rising_edge_select && zc.rise)
    || (zmode == falling_edge_select && zc.fall);
  assign clr_ser = reg_wr && (reg_wdata == 16'h0000)
    && (reg_addr == A_BAT_HI || reg_addr == A_BAT_LO || reg_addr == A_BAT_ST);
  assign clr_ar = ar_run_q && (ar_cnt_q >= ar_dly_q);
  // confirmed menu clear and enabled sum button
  assign clr = clr_lvl || clr_edge || clr_ser || clr_ar
    || (prompt_q && krise[2]) || (cfg_q[F_MAN] && krise[0]);

  always_ff @(posedge mclk) begin
    if (rst) prompt_q <= 1'b0;
    else if (krise[1]) prompt_q <= 1'b1;
    else if (krise[2] || krise[3]) prompt_q <= 1'b0;
  end

  // autoreset delay, in tenths of seconds or of minutes
  assign ar_step = cfg_q[F_AR_MIN] ? AR_MIN_TICKS : AR_SEC_TICKS;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ar_run_q <= 1'b0;
      ar_cnt_q <= 16'h0;
      ar_pre_q <= 16'h0;
    end else if (!cfg_q[F_AR_EN] || clr_ar) begin
      ar_run_q <= 1'b0;
    end else if (krise[4]) begin
      ar_run_q <= 1'b1;
      ar_cnt_q <= 16'h0;
      ar_pre_q <= 16'h0;
    end else if (ar_run_q && tick) begin
      if (16'(ar_pre_q + 16'h1) >= ar_step) begin
        ar_pre_q <= 16'h0;
        ar_cnt_q <= 16'(ar_cnt_q + 16'h1);
      end else begin
        ar_pre_q <= 16'(ar_pre_q + 16'h1);
      end
    end
  end

  // batch counter; a clear outranks any update that cycle
  assign raw_sum = {1'b0, raw_q} + {1'b0, res32};
  always_ff @(posedge mclk) begin
    if (rst || clr) begin
      raw_q <= 32'h0;
      conv_q <= 32'h0;
      ovl_q <= 1'b0;
      raw_stop_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (done && job_q == job_delta && !raw_stop_q) begin
      if (raw_sum >= {1'b0, BATCH_LIMIT}) begin
        raw_q <= BATCH_LIMIT;
        conv_q <= BATCH_LIMIT;
        raw_stop_q <= 1'b1;
        ovl_q <= 1'b1;
      end else begin
        raw_q <= raw_sum[31:0];
      end
    end else if (done && job_q == job_conv && !raw_stop_q && !lock_q) begin
      if (res32 >= BATCH_LIMIT) begin
        conv_q <= BATCH_LIMIT;
        lock_q <= 1'b1;
        ovl_q <= 1'b1;
      end else begin
        conv_q <= res32;
      end
    end
  end

  // Outputs
  assign flow_rate = flow_q;
  assign batch_value = conv_q;
  assign batch_overload = ovl_q;
  assign no_flow = no_flow_q;
  assign clear_prompt = prompt_q;

  ////////////////////////////////////////////////////////////////////////
  // timeout zeroes flow
  flow_zero_a: assert property (@(posedge mclk) disable iff (rst)
    timeout |=> (flow_q == 32'h0) && no_flow_q)
    else $error("flow not zeroed after pulse timeout");
  gap_floor_a: assert property (@(posedge mclk) disable iff (rst)
    (!no_flow_q && gap_q < meas_eff && $stable(meas_q)) |=> !no_flow_q)
    else $error("timeout fired inside the measurement window");
  win_close_a: assert property (@(posedge mclk) disable iff (rst)
    wclose |=> start_q && (jp_q == 16'($past(pcount_q) + 16'h1)))
    else $error("window close lost its pulse count");
  raw_limit_a: assert property (@(posedge mclk) disable iff (rst)
    raw_stop_q |-> (conv_q == BATCH_LIMIT) && ovl_q)
    else $error("raw overload without forced limit");
  conv_lock_a: assert property (@(posedge mclk) disable iff (rst)
    (lock_q && !clr) |=> (conv_q == BATCH_LIMIT) && ovl_q)
    else $error("locked batch value moved");
  ser_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && reg_addr == A_BAT_ST && reg_wdata == 16'h0000)
      |=> (raw_q == 32'h0) && (conv_q == 32'h0) && !ovl_q)
    else $error("serial zero write did not clear batch");
  lvl_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (zmode == zm_high && zc.level)[*2] |=> raw_q == 32'h0)
    else $error("batch not held at zero in level mode");
  auto_reset_a: assert property (@(posedge mclk) disable iff (rst)
    (ar_run_q && ar_cnt_q >= ar_dly_q && cfg_q[F_AR_EN])
      |=> (raw_q == 32'h0) && !ar_run_q)
    else $error("autoreset did not clear batch");
endmodule // pfbc_top
`default_nettype wire

// file: tb/pfbc_sensor.sv
// Pulse flow sensor model: square wave of a set period while enabled
`timescale 1ns/1ps
`default_nettype none
module pfbc_sensor (
  // Clock
  input wire logic mclk,
  // Run control and period in cycles
  input wire logic en,
  input wire logic [15:0] period,
  // Sensor pin
  output logic pulse
);
  logic [15:0] cnt_q;
  // Half high, half low so both states outlast the input filter
  always_ff @(posedge mclk) begin
    cnt_q <= (!en || cnt_q >= period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    pulse <= en && (cnt_q < (period >> 1)); // Pin idles low when stopped
  end
endmodule // pfbc_sensor
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the pulse flow batch counter
`timescale 1ns/1ps
`default_nettype none
module testbench import pfbc_pkg::*;;
  logic mclk, rst, reg_wr, reg_rd, zero_in, en, pls;
  logic [4:0] keys;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, period, rv, rb;
  logic [31:0] flow_rate, batch_value;
  logic batch_overload, no_flow, clear_prompt;
  int n_fail, total_checks, cyc, bat;
  int gain = 1;
  int bsf = 1;
  longint cv;
  // Flow cases: period, config, rate factor low and high, expected milli
  // The last case shows time per unit instead of flow
  int tp[5] = '{1000, 1000, 1000, 3000, 1000};
  logic [15:0] tc[5] = '{16'h0009, 16'h0049, 16'h00a9, 16'h0009, 16'h0019};
  logic [15:0] tf[5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0005, 16'h0001};
  logic [15:0] th[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0000};
  int tx[5] = '{10000, 600000, 36000, 1666, 100};

  pfbc_sensor sensor (.mclk(mclk), .en(en), .period(period), .pulse(pls));
  // Short tick and filter units keep the run brief
  pfbc_top #(.TICK_CYCLES(1000), .FILT_US_CYCLES(1)) DUT (.mclk(mclk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flow_pulse(pls),
    .zero_in(zero_in), .sum_button(keys[0]), .clear_menu(keys[1]),
    .confirm_key(keys[2]), .cancel_key(keys[3]), .batch_done(keys[4]),
    .flow_rate(flow_rate), .batch_value(batch_value),
    .batch_overload(batch_overload), .no_flow(no_flow),
    .clear_prompt(clear_prompt));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      n_fail++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Bus cycles end one edge later so strobes never restart in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    wt(1);
    reg_wr <= 1'b0;
    wt(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    wt(1);
    reg_rd <= 1'b0;
    // Read data are taken at the edge that closes their only cycle
    wt(1);
    d = reg_rdata;
  endtask
  task automatic prs(input int k);
    keys <= 5'h01 << k;
    wt(4);
    keys <= 5'h00;
    wt(8);
  endtask
  // Model: first pulse after idle opens a window, each later one adds a unit
  task automatic run(input int n, input int p, input int idle, input int fx);
    period <= 16'(p);
    en <= 1'b1;
    wt(n * p);
    en <= 1'b0;
    wt(400);
    bat += gain * (n - 1) * 1000;
    // Converted value saturates at the batch limit and flags overload
    cv = longint'(bat) * bsf;
    if (cv > BATCH_LIMIT) cv = BATCH_LIMIT;
    chk("batch", batch_value, 32'(cv));
    chk("overload", batch_overload, cv == BATCH_LIMIT);
    if (fx >= 0) chk("flow", flow_rate, fx);
    wt(idle);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reg_wr, reg_rd, zero_in, en, keys, reg_addr, reg_wdata} = '0;
    period = 16'h03e8;
    rst = 1'b1;
    void'($urandom(32'ha893));
    wt(2);
    rst <= 1'b0;
    wt(1);
    chk("no_flow", no_flow, 1);
    chk("batch", batch_value, 0);
    rd(A_RATE_LO, rv);
    chk("rate_lo", rv, 1);
    rd(8'h20, rv);
    chk("unmapped", rv, 0);
    wr(A_MIN_MEASURE_WINDOW, 16'hffff);
    rd(A_MIN_MEASURE_WINDOW, rv);
    chk("min_measure_window", rv, MIN_MEASURE_WINDOW_MAX);
    rv = 16'($urandom % 400);
    wr(A_ZERO_T, rv);
    rd(A_ZERO_T, rb);
    chk("zero_t", rb, rv);
    wr(A_ZERO_T, 16'h0004);
    wr(A_MIN_MEASURE_WINDOW, 16'h0001);
    wr(A_PPU_LO, 16'h0064);
    // Units, rate factor with decimal point and stretched window
    for (int i = 0; i < 5; i++) begin
      wr(A_CFG, tc[i]);
      wr(A_RATE_LO, tf[i]);
      wr(A_RATE_HI, th[i]);
      run(tp[i] == 1000 ? 2 : 2, tp[i], 4000, tx[i]);
      chk("idle_flow", flow_rate, 0);
      chk("no_flow", no_flow, 1);
    end
    // Low level mode with the pin low clears at once
    wr(A_CFG, 16'h0209);
    wt(1);
    bat = 0;
    chk("batch", batch_value, bat);
    wr(A_CFG, 16'h0009);
    // Timeout below window falls back to the window
    wr(A_ZERO_T, 16'h0000);
    wr(A_MIN_MEASURE_WINDOW, 16'h0002);
    run(3, 1000, 0, -1);
    chk("no_flow", no_flow, 0);
    wt(2000);
    chk("no_flow", no_flow, 1);
    wr(A_MIN_MEASURE_WINDOW, 16'h0001);
    // Serial zero writes
    wr(A_BAT_HI, 16'h0000);
    bat = 0;
    chk("batch", batch_value, bat);
    run(2, 1000, 1600, -1);
    wr(A_BAT_ST, 16'h0000);
    bat = 0;
    chk("batch", batch_value, bat);
    // Sum key and zeroing pin while both are off, then the sum key enabled
    run(2, 1000, 1600, -1);
    prs(0);
    zero_in <= 1'b1;
    wt(5200);
    chk("batch", batch_value, bat);
    wr(A_CFG, 16'h0809);
    prs(0);
    bat = 0;
    chk("batch", batch_value, bat);
    // Local clear: cancel abandons, confirm clears
    run(2, 1000, 1600, -1);
    prs(1);
    chk("prompt", clear_prompt, 1);
    prs(3);
    chk("prompt", clear_prompt, 0);
    chk("batch", batch_value, bat);
    prs(1);
    prs(2);
    bat = 0;
    chk("batch", batch_value, bat);
    // High level holds zero; falling edge, then rising edge clears
    wr(A_CFG, 16'h0109);
    gain = 0;
    run(2, 1000, 1600, -1);
    gain = 1;
    wr(A_CFG, 16'h0409);
    run(2, 1000, 1600, -1);
    zero_in <= 1'b0;
    wt(5200);
    bat = 0;
    chk("batch", batch_value, bat);
    wr(A_CFG, 16'h0309);
    run(2, 1000, 1600, -1);
    zero_in <= 1'b1;
    wt(5200);
    bat = 0;
    chk("batch", batch_value, bat);
    // Autoreset two tenths after batch end; a huge factor locks first
    wr(A_BSF_LO, 16'h423f);
    wr(A_BSF_HI, 16'h000f);
    bsf = 999999;
    run(2, 1000, 1600, -1);
    wr(A_CFG, 16'h1009);
    // delay covers the valve closing time
    wr(A_AR_DLY, 16'h0002);
    prs(4);
    wt(500);
    chk("batch", batch_value, 32'(cv));
    wt(2200);
    chk("batch", batch_value, 0);
    chk("overload", batch_overload, 0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
